// ===== hdl/ecl_regs.vh
// register map, field positions and timing figures of the rom loader
// assumes: included by bare name from the loader design files
`ifndef ECL_REGS_VH
`define ECL_REGS_VH

// register byte offsets, one 32-bit word each
`define ECL_CMD_OFS      8'h00
`define ECL_DATA_OFS     8'h04
`define ECL_RSTCTL_OFS   8'h08
`define ECL_HWCFG_OFS    8'h0C
`define ECL_STA_LO_OFS   8'h10
`define ECL_STA_HI_OFS   8'h14
`define ECL_SOFT_OFS     8'h18

// rom_command_reg fields
`define ECL_BUSY_BIT     31
`define ECL_OP_MSB       30
`define ECL_OP_LSB       28
`define ECL_TMO_BIT      9
`define ECL_LOC_MSB      7

// reset_control_reg and hardware_config_reg fields
`define ECL_DIGRST_BIT   0
`define ECL_READY_BIT    27

// default op code encodings
`define ECL_OP_READ      3'h0
`define ECL_OP_WRITE     3'h3
`define ECL_OP_RELOAD    3'h7

// rom image layout
`define ECL_VALID_FLAG   8'hA5
`define ECL_B_FIRST      4'h0
`define ECL_B_LAST_STA   4'h6
`define ECL_B_STRAPFLAG  4'h7
`define ECL_B_STRAP_LO   4'h8
`define ECL_B_STRAP_HI   4'hB
`define ECL_B_BURSTFLAG  4'hC

// timing: operation timeout and clock rate
`define ECL_TMO_MS       30
`define ECL_CLK_MHZ      100
`define ECL_BOOT_WAIT    2'h3
`define ECL_TMR_W        22

`endif

// ===== hdl/ecl_timer.v
// watchdog counter for one rom access
// assumes: run_in is a level from logic on clk_in; a low level restarts it
`timescale 1ns/1ns
`include "ecl_regs.vh"
module ecl_timer
#(
  parameter WIDTH = `ECL_TMR_W,
  parameter LIMIT = 3000000
)
(
  input  wire clk_in,
  input  wire sys_rst_in,
  input  wire run_in,
  output wire expired_out
);

  // limit minus one, cut to the counter width on purpose
  localparam integer     LAST_I = LIMIT - 1;
  localparam [WIDTH-1:0] LAST   = LAST_I[WIDTH-1:0];

  reg [WIDTH-1:0] count_r;
  reg             expired_r;

  assign expired_out = expired_r;

  // counts while running; at the limit holds the count and pulses every other cycle
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      count_r   <= {WIDTH{1'b0}};
      expired_r <= 1'b0;
    end
    else if (!run_in)
    begin
      count_r   <= {WIDTH{1'b0}};
      expired_r <= 1'b0;
    end
    else
    begin
      expired_r <= (count_r == LAST) && !expired_r;
      if (count_r != LAST)
        count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // ecl_timer

// ===== hdl/ecl_loader.v
// rom command controller and boot loader
// assumes: a byte engine on the far side answers a 4-phase req/ack
// handshake from another clock domain; straps come from pins
`timescale 1ns/1ns
`include "ecl_regs.vh"
module ecl_loader
#(
  parameter [2:0] OP_READ        = `ECL_OP_READ,
  parameter [2:0] OP_WRITE       = `ECL_OP_WRITE,
  parameter [2:0] OP_RELOAD      = `ECL_OP_RELOAD,
  parameter       TIMEOUT_CYCLES = `ECL_TMO_MS * 1000 * `ECL_CLK_MHZ
)
(
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire [7:0]  addr_in,
  input  wire [31:0] wr_data_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output wire [31:0] rd_data_out,
  input  wire [31:0] strap_in,
  output wire        rom_req_out,
  output wire        rom_we_out,
  output wire        rom_seq_out,
  output wire [7:0]  rom_location_out,
  output wire [7:0]  rom_wdata_out,
  input  wire        rom_ack_in,
  input  wire [7:0]  rom_rdata_in,
  output wire [31:0] phy_cfg_out,
  output wire        phy_load_out,
  output wire        device_ready_out
);
  localparam [3:0] ST_BOOT = 4'h0;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_REQ  = 4'h2;
  localparam [3:0] ST_ACK  = 4'h3;
  localparam [3:0] ST_DROP = 4'h4;
  localparam [3:0] ST_NEXT = 4'h5;
  localparam [3:0] ST_PHY  = 4'h6;
  ////////////////////////////////////////////////////////////////////////////
  // state; idx_r is the loader byte index
  reg  [3:0]  state_r, idx_r;
  reg         loader_r;       // sequence belongs to the boot loader
  reg         ready_r, busy_r, timed_out_r, phy_load_r;
  reg         req_r, we_r, seq_r, ack_m_r, ack_s_r;
  reg  [2:0]  rom_op_code_r;
  reg  [1:0]  boot_cnt_r;
  reg  [15:0] sta_hi_r;
  reg  [7:0]  rom_location_r, rom_data_r, strap_flag_r;
  reg  [7:0]  loc_out_r, wdata_out_r, rdat_m_r, rdat_s_r;
  reg  [31:0] sta_lo_r, shadow_r, soft_r, phy_cfg_r;
  reg  [31:0] rd_data_r, strap_m_r, strap_s_r;
  wire        expired, in_access, cmd_wr, go;
  assign rd_data_out      = rd_data_r;
  assign rom_req_out      = req_r;
  assign rom_we_out       = we_r;
  assign rom_seq_out      = seq_r;
  assign rom_location_out = loc_out_r;
  assign rom_wdata_out    = wdata_out_r;
  assign phy_cfg_out      = phy_cfg_r;
  assign phy_load_out     = phy_load_r;
  assign device_ready_out = ready_r;
  // command writes only count while idle; a write during busy is dropped
  assign cmd_wr    = wr_in && (addr_in == `ECL_CMD_OFS) && !busy_r;
  assign go        = cmd_wr && wr_data_in[`ECL_BUSY_BIT];
  assign in_access = (state_r == ST_REQ) || (state_r == ST_ACK) ||
                     (state_r == ST_DROP);
  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: data settles before ack rises, so both stages
  // of the byte are steady by the time the synced ack is seen
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ack_m_r   <= 1'b0;
      ack_s_r   <= 1'b0;
      rdat_m_r  <= 8'h00;
      rdat_s_r  <= 8'h00;
      strap_m_r <= 32'h00000000;
      strap_s_r <= 32'h00000000;
    end
    else
    begin
      ack_m_r   <= rom_ack_in;
      ack_s_r   <= ack_m_r;
      rdat_m_r  <= rom_rdata_in;
      rdat_s_r  <= rdat_m_r;
      strap_m_r <= strap_in;
      strap_s_r <= strap_m_r;
    end
  end

  // access watchdog, restarted for every byte
  ecl_timer #(.WIDTH(`ECL_TMR_W), .LIMIT(TIMEOUT_CYCLES)) u_timer
  (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .run_in      (in_access),
    .expired_out (expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and software-written registers
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_r        <= ST_BOOT;
      loader_r       <= 1'b1;
      ready_r        <= 1'b0;
      busy_r         <= 1'b1;
      timed_out_r    <= 1'b0;
      rom_op_code_r  <= OP_READ;
      rom_location_r <= 8'h00;
      rom_data_r     <= 8'h00;
      idx_r          <= 4'h0;
      boot_cnt_r     <= 2'h0;
      sta_lo_r       <= 32'h00000000;
      sta_hi_r       <= 16'h0000;
      strap_flag_r   <= 8'h00;
      shadow_r       <= 32'h00000000;
      soft_r         <= 32'h00000000;
      phy_cfg_r      <= 32'h00000000;
      phy_load_r     <= 1'b0;
      req_r          <= 1'b0;
      we_r           <= 1'b0;
      seq_r          <= 1'b0;
      loc_out_r      <= 8'h00;
      wdata_out_r    <= 8'h00;
    end
    else
    begin
      phy_load_r <= 1'b0;
      // software side, honoured only while idle
      if (cmd_wr)
      begin
        rom_op_code_r  <= wr_data_in[`ECL_OP_MSB:`ECL_OP_LSB];
        rom_location_r <= wr_data_in[`ECL_LOC_MSB:0];
        if (wr_data_in[`ECL_TMO_BIT])
          timed_out_r <= 1'b0;    // write one to clear
      end
      if (wr_in && (addr_in == `ECL_DATA_OFS) && !busy_r)
        rom_data_r <= wr_data_in[7:0];
      if (go)
      begin
        busy_r <= 1'b1;
        idx_r  <= `ECL_B_FIRST;
        state_r <= ST_REQ;
        if (wr_data_in[`ECL_OP_MSB:`ECL_OP_LSB] == OP_RELOAD)
        begin
          loader_r <= 1'b1;
          ready_r  <= 1'b0;
        end
      end
      // digital reset bit restarts the loader with fresh straps
      if (wr_in && (addr_in == `ECL_RSTCTL_OFS) &&
          wr_data_in[`ECL_DIGRST_BIT])
      begin
        state_r    <= ST_BOOT;
        loader_r   <= 1'b1;
        ready_r    <= 1'b0;
        busy_r     <= 1'b1;
        req_r      <= 1'b0;
        boot_cnt_r <= 2'h0;
      end
      else if (in_access && expired)
      begin
        // abandon: drop the request, report, and stop whatever ran
        req_r       <= 1'b0;
        timed_out_r <= 1'b1;
        busy_r      <= 1'b0;
        loader_r    <= 1'b0;
        ready_r     <= 1'b1;
        state_r     <= ST_IDLE;
      end
      else
      begin
        case (state_r)
          ST_BOOT:
          begin
            // let the strap synchroniser fill before catching it
            boot_cnt_r <= boot_cnt_r + 2'h1;
            if (boot_cnt_r == `ECL_BOOT_WAIT)
            begin
              soft_r  <= strap_s_r;
              idx_r   <= `ECL_B_FIRST;
              state_r <= ST_REQ;
            end
          end
          ST_IDLE:
            if (!(go && (wr_data_in[`ECL_OP_MSB:`ECL_OP_LSB] == OP_RELOAD)))
              ready_r <= 1'b1;
          ST_REQ:
          begin
            // a late ack from an abandoned access must fall first
            if (!ack_s_r)
            begin
              req_r       <= 1'b1;
              we_r        <= !loader_r &&
                             (rom_op_code_r == OP_WRITE);
              seq_r       <= loader_r && (idx_r != `ECL_B_FIRST);
              loc_out_r   <= loader_r ? {4'h0, idx_r} : rom_location_r;
              wdata_out_r <= rom_data_r;
              state_r     <= ST_ACK;
            end
          end
          ST_ACK:
          begin
            if (ack_s_r)
            begin
              req_r   <= 1'b0;
              state_r <= ST_DROP;
              if (!loader_r && (rom_op_code_r == OP_READ))
                rom_data_r <= rdat_s_r;
              if (loader_r)
              begin
                case (idx_r)
                  4'h0: strap_flag_r    <= rdat_s_r;  // byte 0, briefly
                  4'h1: sta_lo_r[7:0]   <= rdat_s_r;
                  4'h2: sta_lo_r[15:8]  <= rdat_s_r;
                  4'h3: sta_lo_r[23:16] <= rdat_s_r;
                  4'h4: sta_lo_r[31:24] <= rdat_s_r;
                  4'h5: sta_hi_r[7:0]   <= rdat_s_r;
                  4'h6: sta_hi_r[15:8]  <= rdat_s_r;
                  4'h7: strap_flag_r    <= rdat_s_r;
                  4'h8: shadow_r[7:0]   <= rdat_s_r;
                  4'h9: shadow_r[15:8]  <= rdat_s_r;
                  4'hA: shadow_r[23:16] <= rdat_s_r;
                  4'hB:
                  begin
                    shadow_r[31:24] <= rdat_s_r;
                    if (strap_flag_r == `ECL_VALID_FLAG)
                      soft_r <= {rdat_s_r, shadow_r[23:0]};
                  end
                  default: shadow_r <= shadow_r;
                endcase
              end
            end
          end
          ST_DROP:
            if (!ack_s_r)
              state_r <= ST_NEXT;
          ST_NEXT:
          begin
            if (!loader_r)
            begin
              busy_r  <= 1'b0;
              state_r <= ST_IDLE;
            end
            else if (idx_r == `ECL_B_FIRST)
              state_r <= (strap_flag_r == `ECL_VALID_FLAG) ?
                         ST_REQ : ST_PHY;
            else if (idx_r == `ECL_B_STRAP_HI)
              state_r <= ST_PHY;
            else if (idx_r == `ECL_B_BURSTFLAG)
            begin
              // burst data is handled elsewhere; either flag ends here
              busy_r   <= 1'b0;
              loader_r <= 1'b0;
              state_r  <= ST_IDLE;
            end
            else
              state_r <= ST_REQ;
            if (loader_r && (idx_r != `ECL_B_STRAP_HI) &&
                (idx_r != `ECL_B_BURSTFLAG))
              idx_r <= idx_r + 4'h1;
          end
          ST_PHY:
          begin
            phy_cfg_r  <= soft_r;
            phy_load_r <= 1'b1;
            if (idx_r == `ECL_B_STRAP_HI)
            begin
              idx_r   <= `ECL_B_BURSTFLAG;
              state_r <= ST_REQ;
            end
            else
            begin
              busy_r   <= 1'b0;
              loader_r <= 1'b0;
              state_r  <= ST_IDLE;
            end
          end
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stands for exactly the cycle after the strobe
  always @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rd_data_r <= 32'h00000000;
    else if (!rd_in)
      rd_data_r <= 32'h00000000;
    else
    begin
      case (addr_in)
        `ECL_CMD_OFS:    rd_data_r <= {busy_r, rom_op_code_r, 18'h00000,
                                       timed_out_r, 1'b0, rom_location_r};
        `ECL_DATA_OFS:   rd_data_r <= {24'h000000, rom_data_r};
        `ECL_HWCFG_OFS:  rd_data_r <= {4'h0, ready_r, 27'h0000000};
        `ECL_STA_LO_OFS: rd_data_r <= sta_lo_r;
        `ECL_STA_HI_OFS: rd_data_r <= {16'h0000, sta_hi_r};
        `ECL_SOFT_OFS:   rd_data_r <= soft_r;
        default:         rd_data_r <= 32'h00000000;
      endcase
    end
  end
endmodule // ecl_loader

// ===== verification/ecl_loader_checker.sv
// checker of the rom loader ports: bus answers, rom handshake, boot run
// assumes: bound to ecl_loader, one clock domain, reset active high
`timescale 1ns/1ns
`include "ecl_regs.vh"
module ecl_loader_checker
#(
  parameter TIMEOUT_CYCLES = 200
)
(
  input wire        clk_in,
  input wire        sys_rst_in,
  input wire [7:0]  addr_in,
  input wire        rd_in,
  input wire [31:0] rd_data_out,
  input wire        rom_req_out,
  input wire        rom_we_out,
  input wire        rom_seq_out,
  input wire [7:0]  rom_location_out,
  input wire [7:0]  rom_wdata_out,
  input wire        phy_load_out,
  input wire        device_ready_out
);
  // a few cycles of slack: the watchdog starts one state before req
  localparam int REQ_MAX = TIMEOUT_CYCLES + 8;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////////////
  property p_rd_idle; !$past(rd_in) |-> rd_data_out == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_ready_rd;
    rd_in && addr_in == `ECL_HWCFG_OFS |=>
      rd_data_out[27] == $past(device_ready_out);
  endproperty
  a_ready_rd: assert property (p_ready_rd)
    else $error("ready bit read wrong");
  property p_phy; phy_load_out |-> !device_ready_out ##1 !phy_load_out;
  endproperty
  a_phy: assert property (p_phy)
    else $error("phy load outside loader");
  property p_wr_ready; rom_req_out && rom_we_out |-> device_ready_out;
  endproperty
  a_wr_ready: assert property (p_wr_ready)
    else $error("loader issued a write");
  property p_hold;
    rom_req_out && $past(rom_req_out) |-> $stable(rom_location_out)
      && $stable(rom_we_out) && $stable(rom_wdata_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request fields moved");
  property p_req_end; $rose(rom_req_out) |-> ##[1:REQ_MAX] !rom_req_out;
  endproperty
  a_req_end: assert property (p_req_end)
    else $error("request never abandoned");
  property p_boot; $fell(sys_rst_in) |-> !device_ready_out [*4];
  endproperty
  a_boot: assert property (p_boot)
    else $error("ready before loader");
  property p_first;
    $rose(rom_req_out) && !device_ready_out && rom_location_out == 8'h00
      |-> !rom_seq_out;
  endproperty
  a_first: assert property (p_first)
    else $error("first byte not a random read");
  property p_seq;
    $rose(rom_req_out) && !device_ready_out && rom_location_out != 8'h00
      |-> rom_seq_out;
  endproperty
  a_seq: assert property (p_seq)
    else $error("loader byte not sequential");
  // main scenarios reached
  c_wr: cover property (rom_req_out && rom_we_out);
  c_phy: cover property (phy_load_out);
  c_rd: cover property (rd_in && addr_in == `ECL_HWCFG_OFS);
endmodule // ecl_loader_checker

bind ecl_loader ecl_loader_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk
(
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
  .rd_in(rd_in), .rd_data_out(rd_data_out), .rom_req_out(rom_req_out),
  .rom_we_out(rom_we_out), .rom_seq_out(rom_seq_out),
  .rom_location_out(rom_location_out), .rom_wdata_out(rom_wdata_out),
  .phy_load_out(phy_load_out), .device_ready_out(device_ready_out)
);

// ===== verification/ecl_rom_model.sv
// byte engine and rom on the far side of the loader's 4-phase link
// assumes: runs on its own slow clock, unrelated to the loader clock
`timescale 1ns/1ns
module ecl_rom_model
(
  input  wire       lclk_in,
  input  wire       req_in,
  input  wire       we_in,
  input  wire [7:0] loc_in,
  input  wire [7:0] wdata_in,
  input  wire       mute_in,
  output reg        ack_out = 1'b0,
  output reg  [7:0] rdata_out = 8'h00
);
  reg [7:0]  mem [0:255];
  reg [1:0]  ph = 2'h0;
  reg [31:0] wcount = 32'h0;
  ////////////////////////////////////////////////////////////////////////
  // data settles one link edge before ack, then is scrambled on release
  always @(posedge lclk_in)
  begin
    if (ph == 2'h0 && req_in && !mute_in)
    begin
      rdata_out <= mem[loc_in];
      if (we_in)
      begin
        mem[loc_in] <= wdata_in;
        wcount <= wcount + 1;
      end
      ph <= 2'h1;
    end
    else if (ph == 2'h1)
    begin
      ack_out <= 1'b1;
      ph <= 2'h2;
    end
    else if (ph == 2'h2 && !req_in)
    begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      ph <= 2'h0;
    end
  end
endmodule // ecl_rom_model

// ===== verification/ecl_loader_bench.sv
// testbench of the rom loader: register tasks, command and boot checks
// assumes: rom model answers on its own 125 ns link clock
`timescale 1ns/1ns
`include "ecl_regs.vh"
module ecl_loader_bench;
  localparam [103:0] IMG = 104'h00_C3_2A_92_81_A5_66_55_44_33_22_11_A5;
  reg         clk_in = 1'b0;
  reg         lclk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdat = 32'h0;
  reg         wr_s = 1'b0;
  reg         rd_s = 1'b0;
  reg  [31:0] strap = 32'h0F0F_0303;
  reg         mute = 1'b0;
  wire [31:0] rdat;
  wire [31:0] phy_cfg;
  wire        req, we, seq, ack, phy_load, ready;
  wire [7:0]  loc, wb, rb;
  reg  [31:0] last_phy = 32'h0;
  reg  [31:0] v;
  integer     phy_cnt = 0;
  integer     miscompares = 0;
  integer     checks_done = 0;
  integer     i;
  ////////////////////////////////////////////////////////////////////////
  always #5 clk_in = ~clk_in;
  // link clock of the rom side, 125 ns period
  always
  begin
    #62 lclk = ~lclk;
    #63 lclk = ~lclk;
  end
  // remember the latest strap set pushed to the phy and count every push
  always @(posedge clk_in)
    if (phy_load === 1'b1)
    begin
      last_phy <= phy_cfg;
      phy_cnt <= phy_cnt + 1;
    end
  ecl_loader #(.TIMEOUT_CYCLES(200)) uut
  (
    .clk_in(clk_in), .sys_rst_in(rst), .addr_in(addr),
    .wr_data_in(wdat), .wr_in(wr_s), .rd_in(rd_s), .rd_data_out(rdat),
    .strap_in(strap), .rom_req_out(req), .rom_we_out(we),
    .rom_seq_out(seq), .rom_location_out(loc), .rom_wdata_out(wb),
    .rom_ack_in(ack), .rom_rdata_in(rb), .phy_cfg_out(phy_cfg),
    .phy_load_out(phy_load), .device_ready_out(ready)
  );
  ecl_rom_model rom
  (
    .lclk_in(lclk), .req_in(req), .we_in(we), .loc_in(loc),
    .wdata_in(wb), .mute_in(mute), .ack_out(ack), .rdata_out(rb)
  );
  ////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk_in);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  end
  endtask
  // data stands only in the cycle after the strobe
  task rd(input [7:0] a, output [31:0] d);
  begin
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    @(negedge clk_in);
    d = rdat;
  end
  endtask
  // poll busy under a bound; a hang ends the run
  task wait_idle;
    integer n;
  begin
    n = 0;
    v = 32'hFFFF_FFFF;
    while (v[31] !== 1'b0 && n < 1000)
    begin
      rd(`ECL_CMD_OFS, v);
      n = n + 1;
    end
    if (v[31] !== 1'b0)
    begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (i = 0; i < 256; i = i + 1)
      rom.mem[i] = (i < 13) ? IMG[8*i +: 8] : 8'hFF;
    repeat (12) @(posedge clk_in);
    rst <= 1'b0;
    rd(`ECL_HWCFG_OFS, v);
    chk(v & 32'h0800_0000, 32'h0);
    wait_idle;
    rd(`ECL_STA_LO_OFS, v);
    chk(v, 32'h4433_2211);
    rd(`ECL_STA_HI_OFS, v);
    chk(v, 32'h0000_6655);
    rd(`ECL_SOFT_OFS, v);
    chk(v, 32'hC32A_9281);
    chk(last_phy, 32'hC32A_9281);
    rd(`ECL_HWCFG_OFS, v);
    chk(v & 32'h0800_0000, 32'h0800_0000);
    chk(rom.wcount, 32'h0);
    // single write then read back of one location
    wr(`ECL_DATA_OFS, 32'h0000_005A);
    wr(`ECL_CMD_OFS, 32'hB000_0020);
    rd(`ECL_CMD_OFS, v);
    chk(v & 32'h8000_0000, 32'h8000_0000);
    wait_idle;
    chk({24'h0, rom.mem[8'h20]}, 32'h0000_005A);
    wr(`ECL_DATA_OFS, 32'h0);
    wr(`ECL_CMD_OFS, 32'h8000_0020);
    wait_idle;
    rd(`ECL_DATA_OFS, v);
    chk(v & 32'hFF, 32'h5A);
    // reload with a bad strap flag keeps the soft straps
    rom.mem[7] = 8'h00;
    rom.mem[1] = 8'h77;
    wr(`ECL_CMD_OFS, 32'hF000_0000);
    wait_idle;
    rd(`ECL_STA_LO_OFS, v);
    chk(v, 32'h4433_2277);
    rd(`ECL_SOFT_OFS, v);
    chk(v, 32'hC32A_9281);
    chk(last_phy, 32'hC32A_9281);
    // reload with a bad first byte stops after the phy push
    rom.mem[0] = 8'h00;
    rom.mem[1] = 8'h99;
    wr(`ECL_CMD_OFS, 32'hF000_0000);
    wait_idle;
    rd(`ECL_STA_LO_OFS, v);
    chk(v, 32'h4433_2277);
    chk(phy_cnt, 3);
    // digital reset catches the pins again
    strap <= 32'h0C15_0A06;
    wr(`ECL_RSTCTL_OFS, 32'h1);
    wait_idle;
    chk(last_phy, 32'h0C15_0A06);
    chk(phy_cnt, 4);
    // silent rom: command abandoned, flag kept until cleared
    mute <= 1'b1;
    wr(`ECL_CMD_OFS, 32'h8000_0005);
    wait_idle;
    chk(v & 32'h8000_0200, 32'h0000_0200);
    mute <= 1'b0;
    rd(`ECL_CMD_OFS, v);
    chk(v & 32'h0000_0200, 32'h0000_0200);
    wr(`ECL_CMD_OFS, 32'h0000_0200);
    rd(`ECL_CMD_OFS, v);
    chk(v & 32'h0000_0200, 32'h0);
    give_verdict;
  end
endmodule // ecl_loader_bench
